/* File: src/pie_pkg.sv */
// Constants for the peripheral interrupt enable and priority slice.
// Assumes a 32-bit classic Wishbone slave, word aligned registers.
// Operation
// RULE1 - Bits 7 to 3 of the timer enable register read zero and ignore writes.
// RULE2 - Enable bit 2 lets the timer-6 match event raise an interrupt, else it is suppressed.
// RULE3 - Enable bit 1 lets the timer-5 overflow event raise an interrupt, else it is blocked.
// RULE4 - Enable bit 0 lets the timer-4 match event raise an interrupt, else it is masked.
// RULE5 - The three enable bits are read/write and clear to zero at reset.
// RULE6 - Bit 0 of priority register B puts capture/compare-2 at high level when one, low when zero.
// RULE7 - Implemented priority bits of registers A and B are read/write, reset to one; A bit 7 reads zero.
// RULE8 - A timer priority register holds timer-6, timer-5, timer-4 priority in bits 2..0, reset zero.
// RULE9 - A flagged and enabled source drives the high request when its priority bit is one, else low.
package pie_pkg;
  localparam logic [7:0] PIE_OFS_ENABLE   = 8'h00;
  localparam logic [7:0] PIE_OFS_PRIO_A   = 8'h04;
  localparam logic [7:0] PIE_OFS_PRIO_B   = 8'h08;
  localparam logic [7:0] PIE_OFS_PRIO_TMR = 8'h0C;
  localparam logic [7:0] PIE_OFS_STATUS   = 8'h10;
  localparam logic [7:0] PIE_OFS_MASK     = 8'h14;
  localparam logic [7:0] PIE_OFS_FLAGS    = 8'h18;
  localparam logic [7:0] PIE_ENABLE_MASK  = 8'h07;
  localparam logic [7:0] PIE_ENABLE_RST   = 8'h00;
  localparam logic [7:0] PIE_PRIO_A_MASK  = 8'h7F;
  localparam logic [7:0] PIE_PRIO_A_RST   = 8'h7F;
  localparam logic [7:0] PIE_PRIO_B_MASK  = 8'hFF;
  localparam logic [7:0] PIE_PRIO_B_RST   = 8'hFF;
  localparam logic [7:0] PIE_PRIO_T_MASK  = 8'h07;
  localparam logic [7:0] PIE_PRIO_T_RST   = 8'h00;
  localparam int PIE_BIT_TIMER4_COUNT = 0;
  localparam int PIE_BIT_TIMER5_COUNT = 1;
  localparam int PIE_BIT_TIMER6_COUNT = 2;
  localparam int PIE_BIT_CCP2 = 0;
  localparam int PIE_NUM_SRC  = 3;
endpackage

/* File: src/pie_route.sv */
// Per-source gating and routing of timer requests to the two levels.
// Assumes flags are already synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module pie_route
  #(parameter int N = 3)
  (input  wire logic [N-1:0] flag_i,  // Source flags
   input  wire logic [N-1:0] en_i,    // Enables
   input  wire logic [N-1:0] prio_i,  // 1 = high level
   output logic      [N-1:0] hi_o,    // High level requests
   output logic      [N-1:0] lo_o);   // Low level requests
  // Refuse an empty source vector at elaboration
  if (N < 1) begin : g_bad_n
    $error("N must be positive");
  end
  genvar g;
  for (g = 0; g < N; g++) begin : g_src
    assign hi_o[g] = flag_i[g] & en_i[g] & prio_i[g];   // RULE9
    assign lo_o[g] = flag_i[g] & en_i[g] & ~prio_i[g];  // RULE9
  end
endmodule
`default_nettype wire

/* File: src/pie_sync.sv */
// Two-flop synchroniser for a vector of pin-side levels.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module pie_sync
  #(parameter int W = 4)
  (input  wire logic         clk_i,  // Clock
   input  wire logic         rst_i,  // Sync reset
   input  wire logic [W-1:0] d_i,    // Async levels
   output logic      [W-1:0] q_o);   // Synchronised
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pie_sync_s;
  // Refuse an empty vector at elaboration
  if (W < 1) begin : g_bad_w
    $error("W must be positive");
  end
  pie_sync_s st_r;
  pie_sync_s st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_o = st_r.s2;
endmodule
`default_nettype wire

/* File: src/pie_top.sv */
// Enable and priority registers for timer interrupt sources, Wishbone slave.
// Assumes classic Wishbone master on clk_i; source flags may be asynchronous.
`timescale 1ns/100ps
`default_nettype none
module pie_top
  import pie_pkg::*;
  (input  wire logic        clk_i,        // 250 MHz clock
   input  wire logic        rst_i,        // Sync reset, high
   input  wire logic        wb_cyc_i,     // Cycle
   input  wire logic        wb_stb_i,     // Strobe
   input  wire logic        wb_we_i,      // Write enable
   input  wire logic [7:0]  wb_adr_i,     // Byte address
   input  wire logic [3:0]  wb_sel_i,     // Byte selects
   input  wire logic [31:0] wb_dat_i,     // Write data
   output logic      [31:0] wb_dat_o,     // Read data
   output logic             wb_ack_o,     // Acknowledge
   output logic             wb_err_o,     // Unmapped address
   input  wire logic        timer4_match_i,   // Timer-4 match flag
   input  wire logic        timer5_overflow_i, // Timer-5 overflow flag
   input  wire logic        timer6_match_i,   // Timer-6 match flag
   input  wire logic        capcomp2_i,       // Capture/compare-2 flag
   output logic             irq_high_o,   // High level request
   output logic             irq_low_o,    // Low level request
   output logic             irq_o);       // Sticky event interrupt
  typedef struct packed {
    logic [7:0]  enable;
    logic [7:0]  prio_a;
    logic [7:0]  prio_b;
    logic [7:0]  prio_t;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [3:0]  evt_prev;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic        hi;
    logic        lo;
  } pie_top_s;
  pie_top_s st_r;
  pie_top_s st_nxt;
  logic [3:0] flags_raw;
  logic [3:0] flags;
  logic [2:0] tmr_hi;
  logic [2:0] tmr_lo;
  logic       req;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [3:0] events;
  logic [3:0] rise;
  assign flags_raw = {capcomp2_i, timer6_match_i, timer5_overflow_i, timer4_match_i};
  pie_sync #(.W(4)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (flags_raw),
    .q_o   (flags)
  );
  pie_route #(.N(PIE_NUM_SRC)) u_route (
    .flag_i (flags[2:0]),
    .en_i   (st_r.enable[2:0]),   // RULE2 RULE3 RULE4
    .prio_i (st_r.prio_t[2:0]),   // RULE8
    .hi_o   (tmr_hi),
    .lo_o   (tmr_lo)
  );
  assign req = wb_cyc_i & wb_stb_i & ~st_r.ack & ~st_r.err;
  // Write commits at the edge where the master samples ack
  assign wr  = wb_cyc_i & wb_stb_i & st_r.ack & wb_we_i & wb_sel_i[0];
  assign rd  = req & ~wb_we_i;
  always_comb begin
    unique case (wb_adr_i)
      PIE_OFS_ENABLE, PIE_OFS_PRIO_A, PIE_OFS_PRIO_B, PIE_OFS_PRIO_TMR,
      PIE_OFS_STATUS, PIE_OFS_MASK, PIE_OFS_FLAGS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // Gated per-source events for the sticky status
  assign events = {flags[3], flags[2:0] & st_r.enable[2:0]};
  assign rise   = events & ~st_r.evt_prev;
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = req & hit;
    st_nxt.err      = req & ~hit;
    st_nxt.evt_prev = events;
    st_nxt.status   = st_r.status | rise;
    if (wr && hit) begin
      unique case (wb_adr_i)
        PIE_OFS_ENABLE:   st_nxt.enable = wb_dat_i[7:0] & PIE_ENABLE_MASK;  // RULE1 RULE5
        PIE_OFS_PRIO_A:   st_nxt.prio_a = wb_dat_i[7:0] & PIE_PRIO_A_MASK;  // RULE7
        PIE_OFS_PRIO_B:   st_nxt.prio_b = wb_dat_i[7:0] & PIE_PRIO_B_MASK;  // RULE7
        PIE_OFS_PRIO_TMR: st_nxt.prio_t = wb_dat_i[7:0] & PIE_PRIO_T_MASK;  // RULE8
        PIE_OFS_MASK:     st_nxt.mask   = wb_dat_i[3:0];
        default:          st_nxt.mask   = st_r.mask;
      endcase
    end
    st_nxt.rdata = 32'h0000_0000;
    if (rd && hit) begin
      unique case (wb_adr_i)
        PIE_OFS_ENABLE:   st_nxt.rdata[7:0] = st_r.enable & PIE_ENABLE_MASK;  // RULE1
        PIE_OFS_PRIO_A:   st_nxt.rdata[7:0] = st_r.prio_a & PIE_PRIO_A_MASK;  // RULE7
        PIE_OFS_PRIO_B:   st_nxt.rdata[7:0] = st_r.prio_b;
        PIE_OFS_PRIO_TMR: st_nxt.rdata[7:0] = st_r.prio_t & PIE_PRIO_T_MASK;
        PIE_OFS_STATUS: begin
          st_nxt.rdata[3:0] = st_r.status;
          st_nxt.status     = rise;  // Read clears, new event wins
        end
        PIE_OFS_MASK:     st_nxt.rdata[3:0] = st_r.mask;
        default:          st_nxt.rdata[3:0] = flags;
      endcase
    end
    // Capture/compare-2 has no enable here; its flag is taken as gated
    st_nxt.hi = (|tmr_hi) | (flags[3] & st_r.prio_b[PIE_BIT_CCP2]);   // RULE6 RULE9
    st_nxt.lo = (|tmr_lo) | (flags[3] & ~st_r.prio_b[PIE_BIT_CCP2]);  // RULE6 RULE9
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.enable   <= PIE_ENABLE_RST;   // RULE5
      st_r.prio_a   <= PIE_PRIO_A_RST;   // RULE7
      st_r.prio_b   <= PIE_PRIO_B_RST;   // RULE7
      st_r.prio_t   <= PIE_PRIO_T_RST;   // RULE8
    end else begin
      st_r <= st_nxt;
    end
  end
  assign wb_dat_o   = st_r.rdata;
  assign wb_ack_o   = st_r.ack;
  assign wb_err_o   = st_r.err;
  assign irq_high_o = st_r.hi;
  assign irq_low_o  = st_r.lo;
  assign irq_o      = |(st_r.status & st_r.mask);
endmodule
`default_nettype wire

/* File: tb/pie_src_model.sv */
// Timer and capture/compare event sources driving level flags.
// Assumes go_i is a one-cycle command from the bench.
`timescale 1ns/100ps
`default_nettype none
module pie_src_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       go_i,    // Start a burst
  input  wire logic [3:0] pat_i,   // Flags to raise
  input  wire logic [3:0] len_i,   // Cycles to hold, minus one
  output logic      [3:0] flag_o); // capcomp2, timer6/5/4
  logic [3:0] cnt_r = 4'h0;
  logic [3:0] flg_r = 4'h0;
  assign flag_o = flg_r;
  always @(posedge clk_i) begin
    if (go_i) begin
      flg_r <= pat_i;
      cnt_r <= len_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      flg_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/pie_top_assertions.sv */
// Port checker for pie_top, attached by bind.
// Assumes flags reach the level requests three edges after the pin.
`timescale 1ns/100ps
`default_nettype none
module pie_chk (
  input  wire logic        clk_i,              // Clock
  input  wire logic        rst_i,              // Sync reset
  input  wire logic        wb_cyc_i,           // Cycle
  input  wire logic        wb_stb_i,           // Strobe
  input  wire logic        wb_we_i,            // Write enable
  input  wire logic [7:0]  wb_adr_i,           // Byte address
  input  wire logic [31:0] wb_dat_o,           // Read data
  input  wire logic        wb_ack_o,           // Acknowledge
  input  wire logic        wb_err_o,           // Unmapped address
  input  wire logic        irq_high_o,         // High level request
  input  wire logic        irq_low_o,          // Low level request
  input  wire logic        irq_o,              // Sticky event interrupt
  input  wire logic        timer4_match_i,     // Timer-4 match flag
  input  wire logic        timer5_overflow_i,  // Timer-5 overflow flag
  input  wire logic        timer6_match_i,     // Timer-6 match flag
  input  wire logic        capcomp2_i);        // Capture/compare-2 flag
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire rd = wb_ack_o && !wb_we_i;
  property p_ans; req |=> wb_ack_o ^ wb_err_o; endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_dat; !rd |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_enrd; rd && wb_adr_i == 8'h00 |-> wb_dat_o[31:3] == 29'h0; endproperty
  a_enrd: assert property (p_enrd) else $error("enable upper bits set");
  property p_pa7; rd && wb_adr_i == 8'h04 |-> wb_dat_o[31:7] == 25'h0; endproperty
  a_pa7: assert property (p_pa7) else $error("priority A bit 7 set");
  property p_src; irq_high_o || irq_low_o
    |-> $past(timer4_match_i || timer5_overflow_i || timer6_match_i || capcomp2_i, 3); endproperty
  a_src: assert property (p_src) else $error("request without flag");
  property p_cc2; $past(capcomp2_i, 3) |-> irq_high_o || irq_low_o; endproperty
  a_cc2: assert property (p_cc2) else $error("capcomp2 flag not routed");
  property p_rst; $fell(rst_i) |-> !wb_ack_o && !irq_high_o && !irq_low_o && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  c_wr: cover property (wb_ack_o && wb_we_i);
  c_err: cover property (wb_err_o);
  c_irq: cover property (irq_o && irq_high_o);
endmodule
bind pie_top pie_chk u_pie_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .irq_high_o, .irq_low_o, .irq_o, .timer4_match_i,
  .timer5_overflow_i, .timer6_match_i, .capcomp2_i);
`default_nettype wire

/* File: tb/periph_irq_enable_priority_tb.sv */
// Self-checking bench for the timer interrupt enable and priority slice.
// Assumes pie_top, its bound checker and the event source model.
`timescale 1ns/100ps
`default_nettype none
module periph_irq_enable_priority_tb import pie_pkg::*; ;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, pat = 4'h0, flg, e, p;
  logic [31:0] dat = 32'h0, rdat, q;
  logic        ack, err, hi, lo, irq;
  int          fail_count = 0, total_checks = 0, cyc_n = 0;
  int          m[6] = '{32'h0, 32'h7F, 32'hFF, 32'h0, 32'h0, 32'h0};
  int          wm[6] = '{32'h7, 32'h7F, 32'hFF, 32'h7, 32'h0, 32'hF};
  always #2 clk_i = ~clk_i;
  pie_top u_pie_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .timer4_match_i(flg[0]), .timer5_overflow_i(flg[1]),
    .timer6_match_i(flg[2]), .capcomp2_i(flg[3]), .irq_high_o(hi), .irq_low_o(lo), .irq_o(irq));
  pie_src_model u_pie_src_model (.clk_i, .go_i(go), .pat_i(pat), .len_i(4'hC), .flag_o(flg));
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1 && ++n < 50);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 50) fail_count++;
  endtask
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, 8'(i * 4), d, s);
    if (s[0]) m[i] = d & wm[i];
  endtask
  task automatic rd(input int i);
    bus(1'b0, 8'(i * 4), 32'h0, 4'hF);
    chk(q, m[i]);
    if (i == 4) m[4] = 0;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 4000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hC510));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(i);
    bus(1'b0, 8'h1C, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 6; i++) if (i != 4) wr(i, $urandom, 4'($urandom));
      for (int i = 0; i < 6; i++) rd(i);
      @(posedge clk_i);
      pat <= 4'($urandom);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (6) @(posedge clk_i);
      e = {1'b1, m[0][2:0]} & pat;
      p = {m[2][0], m[3][2:0]};
      chk({30'h0, hi, lo}, {30'h0, |(e & p), |(e & ~p)});
      m[4] = m[4] | e;
      chk({31'h0, irq}, {31'h0, |(m[4][3:0] & m[5][3:0])});
      bus(1'b0, PIE_OFS_FLAGS, 32'h0, 4'hF);
      chk(q, {28'h0, pat});
      // Let the burst die out before enables change again
      repeat (8) @(posedge clk_i);
    end
    finish_test();
  end
endmodule
`default_nettype wire
